// File: rtl/dsr_status.sv
// DMA controller status reporting registers.
// How it works
// - Channel 3 collision flag sits at bit 3.
// - Channel 2 collision flag sits at bit 2.
// - Channel 1 collision flag sits at bit 1.
// - Channel 0 collision flag sits at bit 0.
// - Collision flag reads one once detected.
// - Collision flag reads zero until detected.
// - Completed transfer loads its channel number.
// - Ping-pong bit is one when secondary selected.
module dsr_status
   import dsr_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic [3:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   input wire logic [7:0] ram_coll_i,
   input wire logic [7:0] done_i,
   input wire logic [7:0] pp_sel_i,
   output logic irq_o
);
   // ****************************************************************
   // Register strobes
   // ****************************************************************
   // Decoded once so that every register and check sees the same hit.
   logic wr_stat0;
   logic wr_irq_stat;
   logic wr_irq_mask;
   assign wr_stat0 = wr_i && (addr_i == STAT0_ADDR);
   assign wr_irq_stat = wr_i && (addr_i == IRQ_STAT_ADDR);
   assign wr_irq_mask = wr_i && (addr_i == IRQ_MASK_ADDR);

   // ****************************************************************
   // Collision flags
   // ****************************************************************
   // Flags are cleared by writing one to the status register, which
   // the documented device leaves open; set still wins a tie.
   logic [7:0] coll_reg;
   logic [7:0] coll_clr;
   assign coll_clr = wr_stat0 ? wdata_i[7:0] : 8'h00;
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++)
      begin : g_coll
         dsr_sticky_flag u_flag (
            .core_clk_i(core_clk_i),
            .nrst_i(nrst_i),
            .set_i(ram_coll_i[g]),
            .clr_i(coll_clr[g]),
            .flag_o(coll_reg[g])
         );
      end
   endgenerate

   // ****************************************************************
   // Last active channel
   // ****************************************************************
   logic [3:0] last_ch_reg;
   logic [3:0] last_ch_next;
   always_comb
   begin
      last_ch_next = last_ch_reg;
      // Higher channel wins if two finish in one cycle.
      for (int i = 0; i < NUM_CH; i++)
      begin
         if (done_i[i])
            last_ch_next = 4'(i);
      end
   end
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         last_ch_reg <= LAST_CH_RESET;
      else
         last_ch_reg <= last_ch_next;
   end

   // ****************************************************************
   // Ping-pong selection
   // ****************************************************************
   logic [7:0] pp_reg;
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         pp_reg <= PPSEL_RESET;
      else
         pp_reg <= pp_sel_i;
   end

   // ****************************************************************
   // Interrupts
   // ****************************************************************
   logic [1:0] irq_stat_reg;
   logic [1:0] irq_mask_reg;
   logic [1:0] irq_set;
   logic [1:0] irq_clr;
   always_comb
   begin
      irq_set = IRQ_RESET;
      irq_set[IRQ_COLL_BIT] = |ram_coll_i;
      irq_set[IRQ_DONE_BIT] = |done_i;
   end
   assign irq_clr = wr_irq_stat ? wdata_i[1:0] : 2'h0;
   // The same flag cell as the collision bits, so an event that meets
   // a clear in one cycle is never lost.
   generate
      for (g = 0; g < 2; g++)
      begin : g_irq
         dsr_sticky_flag u_flag (
            .core_clk_i(core_clk_i),
            .nrst_i(nrst_i),
            .set_i(irq_set[g]),
            .clr_i(irq_clr[g]),
            .flag_o(irq_stat_reg[g])
         );
      end
   endgenerate
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         irq_mask_reg <= IRQ_RESET;
      else if (wr_irq_mask)
         irq_mask_reg <= wdata_i[1:0];
   end
   assign irq_o = |(irq_stat_reg & irq_mask_reg);

   // ****************************************************************
   // Read port
   // ****************************************************************
   logic [15:0] stat0;
   logic [15:0] stat1;
   logic [15:0] rd_mux;
   always_comb
   begin
      stat0 = 16'h0000;
      stat0[3] = coll_reg[3];
      stat0[2] = coll_reg[2];
      stat0[1] = coll_reg[1];
      stat0[0] = coll_reg[0];
      // Channels 4 to 7 keep the same one-bit-per-channel layout.
      stat0[7:4] = coll_reg[7:4];
      stat1 = 16'h0000;
      stat1[LAST_CH_LSB +: LAST_CH_W] = last_ch_reg;
      stat1[7:0] = pp_reg;
   end
   always_comb
   begin
      case (addr_i)
         STAT0_ADDR: rd_mux = stat0;
         STAT1_ADDR: rd_mux = stat1;
         IRQ_STAT_ADDR: rd_mux = {14'h0000, irq_stat_reg};
         IRQ_MASK_ADDR: rd_mux = {14'h0000, irq_mask_reg};
         default: rd_mux = 16'h0000;
      endcase
   end
   // Read data stand for one cycle only and fall back to zero, so a
   // stale word is never mistaken for a fresh one.
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rdata_o <= 16'h0000;
      else if (rd_i)
         rdata_o <= rd_mux;
      else
         rdata_o <= 16'h0000;
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   sequence stat0_read_s;
      rd_i && addr_i == STAT0_ADDR;
   endsequence
   sequence stat1_read_s;
      rd_i && addr_i == STAT1_ADDR;
   endsequence
   sequence irq_read_s;
      rd_i && addr_i == IRQ_STAT_ADDR;
   endsequence
   sequence mask_read_s;
      rd_i && addr_i == IRQ_MASK_ADDR;
   endsequence
   coll_sets_a:
      assert property (ram_coll_i[3] |=> coll_reg[3])
      else $error("collision flag not set");
   coll_stays_a:
      assert property (!ram_coll_i[0] && !coll_reg[0] |=> !coll_reg[0])
      else $error("collision flag set without cause");
   coll_read_a:
      assert property (stat0_read_s |=> rdata_o[3:0] == $past(coll_reg[3:0]))
      else $error("collision read wrong");
   bit2_read_a:
      assert property (rd_i && addr_i == STAT0_ADDR && coll_reg[2]
         |=> rdata_o[2])
      else $error("bit 2 wrong");
   bit1_read_a:
      assert property (rd_i && addr_i == STAT0_ADDR && !coll_reg[1]
         |=> !rdata_o[1])
      else $error("bit 1 wrong");
   bit0_read_a:
      assert property (rd_i && addr_i == STAT0_ADDR && coll_reg[0]
         |=> rdata_o[0])
      else $error("bit 0 wrong");
   last_load_a:
      assert property (done_i == 8'h20 |=> last_ch_reg == 4'h5)
      else $error("last channel not loaded");
   last_read_a:
      assert property (stat1_read_s
         |=> rdata_o[15:8] == {4'h0, $past(last_ch_reg)})
      else $error("last channel read wrong");
   pp_track_a:
      assert property (pp_sel_i[6] |=> rd_i && addr_i ==
         STAT1_ADDR |=> rdata_o[6] || !$past(pp_reg[6]))
      else $error("ping-pong read wrong");
   coll_any_set_a:
      assert property (ram_coll_i != 8'h00
         |=> (coll_reg & $past(ram_coll_i)) == $past(ram_coll_i))
      else $error("collision flag missed an event");
   coll_hold_a:
      assert property (ram_coll_i == 8'h00 && !wr_stat0
         |=> coll_reg == $past(coll_reg))
      else $error("collision flag changed on its own");
   coll_no_cause_a:
      assert property (ram_coll_i == 8'h00
         |=> (coll_reg & ~$past(coll_reg)) == 8'h00)
      else $error("collision flag rose without cause");
   bit3_clear_a:
      assert property (wr_stat0 && wdata_i[3] && !ram_coll_i[3]
         |=> !coll_reg[3])
      else $error("collision flag not cleared");
   bit3_read_a:
      assert property (stat0_read_s |=> rdata_o[3] == $past(coll_reg[3]))
      else $error("bit 3 wrong");
   bit2_match_a:
      assert property (stat0_read_s |=> rdata_o[2] == $past(coll_reg[2]))
      else $error("bit 2 does not match");
   bit1_match_a:
      assert property (stat0_read_s |=> rdata_o[1] == $past(coll_reg[1]))
      else $error("bit 1 does not match");
   bit0_match_a:
      assert property (stat0_read_s |=> rdata_o[0] == $past(coll_reg[0]))
      else $error("bit 0 does not match");
   stat0_upper_a:
      assert property (stat0_read_s |=> rdata_o[15:8] == 8'h00)
      else $error("status zero upper byte not zero");
   last_hold_a:
      assert property (done_i == 8'h00
         |=> last_ch_reg == $past(last_ch_reg))
      else $error("last channel changed without transfer");
   last_range_a:
      assert property (last_ch_reg != LAST_CH_RESET |-> !last_ch_reg[3])
      else $error("last channel out of range");
   last_top_a:
      assert property (stat1_read_s |=> rdata_o[15:12] == 4'h0)
      else $error("status one top bits not zero");
   pp_read_a:
      assert property (stat1_read_s |=> rdata_o[7:0] == $past(pp_reg))
      else $error("ping-pong byte wrong");
   irq_coll_a:
      assert property (ram_coll_i != 8'h00 |=> irq_stat_reg[IRQ_COLL_BIT])
      else $error("collision event not flagged");
   irq_done_a:
      assert property (done_i != 8'h00 |=> irq_stat_reg[IRQ_DONE_BIT])
      else $error("done event not flagged");
   irq_clear_a:
      assert property (wr_irq_stat && wdata_i[1] && done_i == 8'h00
         |=> !irq_stat_reg[IRQ_DONE_BIT])
      else $error("done event not cleared");
   irq_masked_a:
      assert property (irq_mask_reg == 2'h0 |-> !irq_o)
      else $error("masked interrupt raised");
   mask_write_a:
      assert property (wr_irq_mask
         |=> irq_mask_reg == $past(wdata_i[1:0]))
      else $error("mask not written");
   irq_read_a:
      assert property (irq_read_s
         |=> rdata_o == {14'h0000, $past(irq_stat_reg)})
      else $error("interrupt status read wrong");
   mask_read_a:
      assert property (mask_read_s
         |=> rdata_o == {14'h0000, $past(irq_mask_reg)})
      else $error("mask read wrong");
   rd_idle_a:
      assert property (!rd_i |=> rdata_o == 16'h0000)
      else $error("read data without strobe");
   unmapped_a:
      assert property (rd_i && addr_i > IRQ_MASK_ADDR
         |=> rdata_o == 16'h0000)
      else $error("unmapped read not zero");
   generate
      for (g = 0; g < NUM_CH; g++)
      begin : g_chk
         ch_set_a:
            assert property (ram_coll_i[g] |=> coll_reg[g])
            else $error("channel collision flag not set");
         ch_clear_a:
            assert property (coll_clr[g] && !ram_coll_i[g] |=> !coll_reg[g])
            else $error("channel collision flag not cleared");
         ch_done_a:
            assert property (done_i[g] && (done_i >> (g + 1)) == 8'h00
               |=> last_ch_reg == 4'(g))
            else $error("channel number not loaded");
         ch_pp_a:
            assert property (stat1_read_s |=> rdata_o[g] == $past(pp_reg[g]))
            else $error("channel ping-pong bit wrong");
      end
   endgenerate
endmodule : dsr_status

// File: rtl/dsr_pkg.sv
// Package of offsets, field positions and reset values for DMA status.
package dsr_pkg;
   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [3:0] STAT0_ADDR = 4'h0;
   localparam logic [3:0] STAT1_ADDR = 4'h1;
   localparam logic [3:0] IRQ_STAT_ADDR = 4'h2;
   localparam logic [3:0] IRQ_MASK_ADDR = 4'h3;
   // ****************************************************************
   // Fields
   // ****************************************************************
   localparam int NUM_CH = 8;
   localparam int LAST_CH_LSB = 8;
   localparam int LAST_CH_W = 4;
   localparam logic [3:0] LAST_CH_RESET = 4'hF;
   localparam logic [7:0] COLL_RESET = 8'h00;
   localparam logic [7:0] PPSEL_RESET = 8'h00;
   localparam logic [1:0] IRQ_RESET = 2'h0;
   localparam int IRQ_COLL_BIT = 0;
   localparam int IRQ_DONE_BIT = 1;
endpackage : dsr_pkg

// File: rtl/dsr_sticky_flag.sv
// One sticky flag: set wins over clear.
module dsr_sticky_flag
   import dsr_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic set_i,
   input wire logic clr_i,
   output logic flag_o
);
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         flag_o <= 1'b0;
      else if (set_i)
         flag_o <= 1'b1;
      else if (clr_i)
         flag_o <= 1'b0;
   end
endmodule : dsr_sticky_flag

// File: tb/tb_dsr_status.sv
// Self-checking testbench for the DMA status registers.
module tb_dsr_status
   import dsr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [15:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [15:0] rdata_o;
   logic [7:0] ram_coll_i = 8'h00;
   logic [7:0] done_i = 8'h00;
   logic [7:0] pp_sel_i = 8'h00;
   logic irq_o;
   logic [7:0] seed = 8'h56;
   logic [15:0] v;
   int errors = 0;
   int checked = 0;
   dsr_status dsr_status_inst (.core_clk_i, .nrst_i, .addr_i, .wdata_i,
      .wr_i, .rd_i, .rdata_o, .ram_coll_i, .done_i, .pp_sel_i, .irq_o);
   // ***************************************************************
   // Expectations and bus tasks
   // ***************************************************************
   function automatic logic [7:0] lfsr_step(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr_step
   function automatic logic [15:0] stat1_exp(input logic [3:0] c,
                                             input logic [7:0] p);
      return {4'h0, c, p};
   endfunction : stat1_exp
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e)
      begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // Read data stand only in the cycle after the strobe, so sample then.
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      @(negedge core_clk_i);
      d = rdata_o;
   endtask : rd
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic pulse(input logic [7:0] c, input logic [7:0] dn,
                        input logic [7:0] p);
      @(posedge core_clk_i);
      ram_coll_i <= c;
      done_i <= dn;
      pp_sel_i <= p;
      @(posedge core_clk_i);
      ram_coll_i <= 8'h00;
      done_i <= 8'h00;
   endtask : pulse
   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   initial
      forever #20 core_clk_i = ~core_clk_i;
   // The run needs some 140 cycles; a hang is cut well after that.
   initial
   begin
      repeat (3000) @(posedge core_clk_i);
      errors++;
      wrap_up();
   end
   initial
   begin
      repeat (6) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      rd(STAT0_ADDR, v);
      chk(v, {8'h00, COLL_RESET});
      rd(STAT1_ADDR, v);
      chk(v, stat1_exp(LAST_CH_RESET, 8'h00));
      @(negedge core_clk_i);
      chk(rdata_o, 16'h0000);
      $display("Test reset values done");
      pulse(8'h0F, 8'h00, 8'h00);
      wr(STAT0_ADDR, 16'h0005);
      rd(STAT0_ADDR, v);
      chk(v, 16'h000A);
      wr(STAT0_ADDR, 16'h000A);
      for (int i = 0; i < 8; i++)
      begin
         seed = lfsr_step(seed);
         pulse(seed, 8'h00, 8'h00);
         rd(STAT0_ADDR, v);
         chk(v, {8'h00, seed});
         wr(STAT0_ADDR, {8'h00, seed});
         rd(STAT0_ADDR, v);
         chk(v, 16'h0000);
      end
      $display("Test collision flags done");
      for (int k = 0; k < 8; k++)
      begin
         seed = lfsr_step(seed);
         pulse(8'h00, 8'h01 << k, seed);
         rd(STAT1_ADDR, v);
         chk(v, stat1_exp(4'(k), seed));
      end
      wr(STAT1_ADDR, 16'hFFFF);
      rd(STAT1_ADDR, v);
      chk(v, stat1_exp(4'h7, seed));
      rd(4'hF, v);
      chk(v, 16'h0000);
      $display("Test last channel and unmapped done");
      wr(IRQ_MASK_ADDR, 16'h0000);
      rd(IRQ_STAT_ADDR, v);
      chk(v, 16'h0003);
      chk({15'h0000, irq_o}, 16'h0000);
      wr(IRQ_MASK_ADDR, 16'h0002);
      @(negedge core_clk_i);
      chk({15'h0000, irq_o}, 16'h0001);
      wr(IRQ_STAT_ADDR, 16'h0002);
      @(negedge core_clk_i);
      chk({15'h0000, irq_o}, 16'h0000);
      rd(IRQ_STAT_ADDR, v);
      chk(v, 16'h0001);
      rd(IRQ_MASK_ADDR, v);
      chk(v, 16'h0002);
      $display("Test interrupt done");
      @(posedge core_clk_i);
      nrst_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      rd(STAT1_ADDR, v);
      chk(v, stat1_exp(LAST_CH_RESET, seed));
      rd(IRQ_STAT_ADDR, v);
      chk(v, 16'h0000);
      $display("Test mid-run reset done");
      wrap_up();
   end
endmodule : tb_dsr_status
